// *** dv/pkrps_assertions.sv ***
// Purpose: Port-level checks of pkrps_top
// Assumes: Pad levels reach registers three edges after the pad
// Notes:   Bound to every instance of pkrps_top
`timescale 1ns/1ps

module pkrps_assertions
	import pkrps_pkg::*;
(
	input wire logic                              clk,
	input wire logic                              sys_rst,
	input wire logic                              wb_cyc_i,
	input wire logic                              wb_stb_i,
	input wire logic [pkrps_pkg::DATA_WIDTH-1:0]  wb_dat_o,
	input wire logic                              wb_ack_o,
	input wire logic [pkrps_pkg::PORT0_PINS-1:0]  port0PinIn,
	input wire logic [pkrps_pkg::PORT0_PINS-1:0]  port0PinOut,
	input wire logic [pkrps_pkg::PORT0_PINS-1:0]  port0PinOe,
	input wire logic [pkrps_pkg::PORT0_PINS-1:0]  gpio0Out,
	input wire logic [pkrps_pkg::PORT0_PINS-1:0]  gpio0Oe,
	input wire logic                              uartRxIn,
	input wire logic                              uartSerialClockIn,
	input wire logic                              timerExtClockIn,
	input wire logic                              keyResetReq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_key_low: assert property (keyResetReq |-> !$past(port0PinIn[0], 3) && !$past(port0PinIn[1], 3))
		else $error("key reset with a high key pin");
	a_rx_level: assert property (!uartRxIn |-> !$past(port0PinIn[0], 3))
		else $error("receive input low while pin high");
	a_tim_level: assert property (timerExtClockIn |-> $past(port0PinIn[3], 3))
		else $error("timer clock high while pin low");
	a_sclk_level: assert property (uartSerialClockIn |-> $past(port0PinIn[2], 3))
		else $error("serial clock high while pin low");
	a_upper_gpio: assert property (1'b1 |=> port0PinOut[7:4] == $past(gpio0Out[7:4])
		&& port0PinOe[7:4] == $past(gpio0Oe[7:4]))
		else $error("upper pins not on gpio");
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> !keyResetReq
		&& uartRxIn && port0PinOe == 8'h00)
		else $error("outputs not idle after reset");
endmodule : pkrps_assertions

bind pkrps_top pkrps_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port0PinIn(port0PinIn),
	.port0PinOut(port0PinOut), .port0PinOe(port0PinOe), .gpio0Out(gpio0Out),
	.gpio0Oe(gpio0Oe), .uartRxIn(uartRxIn), .uartSerialClockIn(uartSerialClockIn),
	.timerExtClockIn(timerExtClockIn), .keyResetReq(keyResetReq));

// *** dv/pkrps_pad_model.sv ***
// Purpose: Pads with external keys behind them
// Assumes: Keys pull a pin low; released keys leave it high
// Notes:   A driven pad shows the device's own level
`timescale 1ns/1ps

module pkrps_pad_model (
	input  wire logic [7:0] padOut,
	input  wire logic [7:0] padOe,
	input  wire logic [7:0] keyLevel0,
	input  wire logic [3:0] keyLevel1,
	output logic      [7:0] padLevel0,
	output logic      [3:0] padLevel1
);
	// Device drive wins over the key network
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			padLevel0[i] = padOe[i] ? padOut[i] : keyLevel0[i];
		padLevel1 = keyLevel1;
	end
endmodule : pkrps_pad_model

// *** dv/pkrps_top_tb.sv ***
// Purpose: Register and pin tests of pkrps_top
// Assumes: One-cycle ack, three-edge pad sampling
// Notes:   Tests are sequences of bus calls
`timescale 1ns/1ps

`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module pkrps_top_tb;
	import pkrps_pkg::*;
	logic        clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, krq;
	logic [17:0] adr = 0;
	logic [31:0] dwr = 0, drd;
	logic [3:0]  sel = 0, pin1, ext1 = 4'hf;
	logic [7:0]  pin0, pOut, pOe, gOut = 0, gOe = 0, ext0 = 8'hff, q;
	logic        rx, txo = 1, sclkIn, sclkOut = 1, sclkOe = 1, clka = 1, tim, lcd = 1;
	int          miscompares = 0, nCompared = 0;
	logic [7:0]  fs [4] = '{8'he5, 8'h5a, 8'hbf, 8'h00};
	logic [6:0]  ex [4] = '{7'h70, 7'h27, 7'h04, 7'h04};
	logic [3:0]  lo;

	pkrps_top dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dwr), .wb_sel_i(sel), .wb_dat_o(drd), .wb_ack_o(ack),
		.port0PinIn(pin0), .port0PinOut(pOut), .port0PinOe(pOe), .port1PinIn(pin1),
		.gpio0Out(gOut), .gpio0Oe(gOe), .uartRxIn(rx), .uartTxOut(txo),
		.uartSerialClockIn(sclkIn), .uartSerialClockOut(sclkOut),
		.uartSerialClockOe(sclkOe), .clockGenOutputA(clka), .timerExtClockIn(tim),
		.lcdFrameSignal(lcd), .keyResetReq(krq));
	pkrps_pad_model pads (.padOut(pOut), .padOe(pOe), .keyLevel0(ext0), .keyLevel1(ext1),
		.padLevel0(pin0), .padLevel1(pin1));

	initial
	begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dwr <= {24'h0, d}; sel <= s;
		do
		begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = drd[7:0];
		cyc <= 0; stb <= 0; we <= 0;
	endtask : acc

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 4'h1);
	endtask : wr

	task automatic rd(input logic [17:0] a);
		acc(1'b0, a, 8'h00, 4'h0);
	endtask : rd

	task automatic settle;
		repeat (5) @(posedge clk);
	endtask : settle

	task automatic end_of_test;
		$display("compared %0d miscompares %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		miscompares++;
		end_of_test;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		rd(KEY_RESET_CONFIG_ADDR);         `CHK("krst", 8'h00, q)
		rd(PORT0_INPUT_ENABLE_ADDR);       `CHK("ien0", 8'hff, q)
		rd(PORT1_INPUT_ENABLE_ADDR);       `CHK("ien1", 8'h0f, q)
		rd(LOW_PINS_FUNCTION_SELECT_ADDR); `CHK("fsel", 8'h00, q)
		$display("test reset values done");
		wr(KEY_RESET_CONFIG_ADDR, 8'hff);
		rd(KEY_RESET_CONFIG_ADDR);         `CHK("krst", 8'h03, q)
		wr(PORT1_INPUT_ENABLE_ADDR, 8'hff);
		rd(PORT1_INPUT_ENABLE_ADDR);       `CHK("ien1", 8'h0f, q)
		acc(1'b1, LOW_PINS_FUNCTION_SELECT_ADDR, 8'h55, 4'h0);
		rd(LOW_PINS_FUNCTION_SELECT_ADDR); `CHK("fsel", 8'h00, q)
		wr(18'h00100, 8'h77);
		rd(18'h00100);                     `CHK("unmapped", 8'h00, q)
		wr(KEY_RESET_CONFIG_ADDR, 8'h00);
		$display("test register access done");
		ext0 <= 8'h5a; ext1 <= 4'h9; gOut <= 8'h0f; gOe <= 8'h81;
		settle;
		rd(PORT0_INPUT_DATA_ADDR);         `CHK("in0", 8'h5b, q)
		rd(PORT1_INPUT_DATA_ADDR);         `CHK("in1", 8'h09, q)
		wr(PORT0_INPUT_ENABLE_ADDR, 8'h0f);
		wr(PORT1_INPUT_ENABLE_ADDR, 8'h03);
		rd(PORT0_INPUT_ENABLE_ADDR);       `CHK("ien0", 8'h0f, q)
		rd(PORT0_INPUT_DATA_ADDR);         `CHK("in0", 8'h0b, q)
		rd(PORT1_INPUT_DATA_ADDR);         `CHK("in1", 8'h01, q)
		wr(PORT0_INPUT_ENABLE_ADDR, 8'hff);
		ext0 <= 8'hff; ext1 <= 4'hf; gOut <= 8'h00; gOe <= 8'h00;
		$display("test input enable done");
		for (int c = 0; c < 4; c++)
		begin
			lo = (c == 0) ? 4'hf : 4'((2 << c) - 1);
			wr(KEY_RESET_CONFIG_ADDR, 8'(c));
			ext0 <= {4'hf, ~(lo >> 1)};
			settle;
			`CHK("keyReq", 1'b0, krq)
			ext0 <= {4'hf, ~lo};
			settle;
			`CHK("keyReq", c != 0, krq)
		end
		ext0 <= 8'hfe;
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		rd(KEY_RESET_CONFIG_ADDR);         `CHK("krst", 8'h00, q)
		$display("test key reset done");
		for (int i = 0; i < 4; i++)
		begin
			wr(LOW_PINS_FUNCTION_SELECT_ADDR, fs[i]);
			settle;
			rd(LOW_PINS_FUNCTION_SELECT_ADDR); `CHK("fsel", fs[i], q)
			`CHK("pinOut", ex[i][6:3], pOut[3:0])
			`CHK("pinOe", ex[i][6:3], pOe[3:0])
			`CHK("rx", ex[i][2], rx)
			`CHK("tim", ex[i][1], tim)
			`CHK("sclk", ex[i][0], sclkIn)
		end
		$display("test function select done");
		end_of_test;
	end
endmodule : pkrps_top_tb

// *** verilog/pkrps_pkg.sv ***
// Purpose: Constants for the port key-reset and pin-select block
// Assumes: Registers are 8 bits wide, one per 32-bit Wishbone word
// Notes:   Byte address of a register is four times its index
package pkrps_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// Register indices and byte addresses
	localparam logic [15:0] KEY_RESET_CONFIG_IDX         = 16'h5209;
	localparam logic [15:0] PORT0_INPUT_ENABLE_IDX       = 16'h520a;
	localparam logic [15:0] PORT1_INPUT_ENABLE_IDX       = 16'h521a;
	localparam logic [15:0] LOW_PINS_FUNCTION_SELECT_IDX = 16'h52a0;
	localparam logic [15:0] PORT0_INPUT_DATA_IDX         = 16'h5200;
	localparam logic [15:0] PORT1_INPUT_DATA_IDX         = 16'h5210;

	localparam int          ADDR_WIDTH = 18;
	localparam int          DATA_WIDTH = 32;

	localparam logic [17:0] KEY_RESET_CONFIG_ADDR         = {KEY_RESET_CONFIG_IDX, 2'b00};
	localparam logic [17:0] PORT0_INPUT_ENABLE_ADDR       = {PORT0_INPUT_ENABLE_IDX, 2'b00};
	localparam logic [17:0] PORT1_INPUT_ENABLE_ADDR       = {PORT1_INPUT_ENABLE_IDX, 2'b00};
	localparam logic [17:0] LOW_PINS_FUNCTION_SELECT_ADDR = {LOW_PINS_FUNCTION_SELECT_IDX, 2'b00};
	localparam logic [17:0] PORT0_INPUT_DATA_ADDR         = {PORT0_INPUT_DATA_IDX, 2'b00};
	localparam logic [17:0] PORT1_INPUT_DATA_ADDR         = {PORT1_INPUT_DATA_IDX, 2'b00};

	//////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [1:0] KEY_RESET_GROUP_SEL_RST = 2'h0;
	localparam logic [7:0] PORT0_INPUT_ENABLE_RST  = 8'hff;
	localparam logic [3:0] PORT1_INPUT_ENABLE_RST  = 4'hf;
	localparam logic [7:0] FUNCTION_SELECT_RST     = 8'h00;

	//////////////////////////////////////////////////////////////////////////////
	// Field positions in the function select register
	localparam int PIN0_SEL_LSB = 0;
	localparam int PIN1_SEL_LSB = 2;
	localparam int PIN2_SEL_LSB = 4;
	localparam int PIN3_SEL_LSB = 6;

	// Key-entry group codes
	localparam logic [1:0] KEY_GROUP_OFF    = 2'h0;
	localparam logic [1:0] KEY_GROUP_PINS01 = 2'h1;
	localparam logic [1:0] KEY_GROUP_PINS02 = 2'h2;
	localparam logic [1:0] KEY_GROUP_PINS03 = 2'h3;

	// Function codes
	localparam logic [1:0] FUNC_GPIO        = 2'h0;
	localparam logic [1:0] PIN0_FUNC_UARTRX = 2'h1;
	localparam logic [1:0] PIN1_FUNC_UARTTX = 2'h1;
	localparam logic [1:0] PIN2_FUNC_SCLK   = 2'h1;
	localparam logic [1:0] PIN2_FUNC_CLKA   = 2'h2;
	localparam logic [1:0] PIN3_FUNC_TIMCLK = 2'h1;
	localparam logic [1:0] PIN3_FUNC_LCDFR  = 2'h3;

	// Pin count of the first and second port
	localparam int PORT0_PINS = 8;
	localparam int PORT1_PINS = 4;

endpackage : pkrps_pkg

// *** verilog/pkrps_top.sv ***
// Purpose: Key-entry reset, input enables and low-pin function select
// Assumes: Classic Wishbone slave, 8-bit registers in byte lane 0
// Notes:   All pin levels pass two flip-flops before any logic reads them
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

module pkrps_top
	import pkrps_pkg::*;
(
	input  wire logic                                 clk,
	input  wire logic                                 sys_rst,
	// Wishbone slave
	input  wire logic                                 wb_cyc_i,
	input  wire logic                                 wb_stb_i,
	input  wire logic                                 wb_we_i,
	input  wire logic [pkrps_pkg::ADDR_WIDTH-1:0]     wb_adr_i,
	input  wire logic [pkrps_pkg::DATA_WIDTH-1:0]     wb_dat_i,
	input  wire logic [3:0]                           wb_sel_i,
	output logic      [pkrps_pkg::DATA_WIDTH-1:0]     wb_dat_o,
	output logic                                      wb_ack_o,
	// Pads
	input  wire logic [pkrps_pkg::PORT0_PINS-1:0]     port0PinIn,
	output logic      [pkrps_pkg::PORT0_PINS-1:0]     port0PinOut,
	output logic      [pkrps_pkg::PORT0_PINS-1:0]     port0PinOe,
	input  wire logic [pkrps_pkg::PORT1_PINS-1:0]     port1PinIn,
	// GPIO controls from the port data logic
	input  wire logic [pkrps_pkg::PORT0_PINS-1:0]     gpio0Out,
	input  wire logic [pkrps_pkg::PORT0_PINS-1:0]     gpio0Oe,
	// Peripheral signals
	output logic                                      uartRxIn,
	input  wire logic                                 uartTxOut,
	output logic                                      uartSerialClockIn,
	input  wire logic                                 uartSerialClockOut,
	input  wire logic                                 uartSerialClockOe,
	input  wire logic                                 clockGenOutputA,
	output logic                                      timerExtClockIn,
	input  wire logic                                 lcdFrameSignal,
	// Chip initial reset request
	output logic                                      keyResetReq
);
	import pkrps_pkg::*;

	//////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [PORT0_PINS-1:0] sync0Stage1;
		logic [PORT0_PINS-1:0] sync0Stage2;
		logic [PORT1_PINS-1:0] sync1Stage1;
		logic [PORT1_PINS-1:0] sync1Stage2;
		logic [1:0]            keyResetGroupSel;
		logic [PORT0_PINS-1:0] port0InputEnable;
		logic [PORT1_PINS-1:0] port1InputEnable;
		logic [1:0]            pin0FunctionSel;
		logic [1:0]            pin1FunctionSel;
		logic [1:0]            pin2FunctionSel;
		logic [1:0]            pin3FunctionSel;
		logic [PORT0_PINS-1:0] port0InputData;
		logic [PORT1_PINS-1:0] port1InputData;
		logic [PORT0_PINS-1:0] pinOut;
		logic [PORT0_PINS-1:0] pinOe;
		logic                  uartRx;
		logic                  uartSclkIn;
		logic                  timerClkIn;
		logic                  keyReset;
		logic                  ack;
		logic [DATA_WIDTH-1:0] readData;
	} pkrps_state_type;

	pkrps_state_type state_q;
	pkrps_state_type state_d;

	logic                  busReq;
	logic                  busWrite;
	logic [7:0]            wrByte;
	logic [7:0]            rdByte;
	logic [3:0]            keyMask;
	logic [3:0]            keyPressed;
	logic                  keyAllLow;
	logic [7:0]            funcSelReg;
	logic [PORT0_PINS-1:0] gatedPort0;
	logic [PORT1_PINS-1:0] gatedPort1;

	//////////////////////////////////////////////////////////////////////////////
	// Bus decode helpers

	// Request is answered one cycle later; the write lands at the ack edge
	assign busReq   = wb_cyc_i & wb_stb_i & ~state_q.ack;
	assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & state_q.ack & wb_sel_i[0];
	assign wrByte   = wb_dat_i[7:0];

	assign funcSelReg = {state_q.pin3FunctionSel, state_q.pin2FunctionSel,
		state_q.pin1FunctionSel, state_q.pin0FunctionSel};

	// Input path gated per pin by its enable; a disabled pin reads as zero
	for (genvar b = 0; b < PORT0_PINS; b++)
	begin : g_gate0
		assign gatedPort0[b] = state_q.sync0Stage2[b] & state_q.port0InputEnable[b];
	end
	for (genvar b = 0; b < PORT1_PINS; b++)
	begin : g_gate1
		assign gatedPort1[b] = state_q.sync1Stage2[b] & state_q.port1InputEnable[b];
	end

	//////////////////////////////////////////////////////////////////////////////
	// Key-entry group detection

	always_comb
	begin
		case (state_q.keyResetGroupSel)
			KEY_GROUP_PINS03: keyMask = 4'hf;
			KEY_GROUP_PINS02: keyMask = 4'h7;
			KEY_GROUP_PINS01: keyMask = 4'h3;
			KEY_GROUP_OFF:    keyMask = 4'h0;
			default:          keyMask = 4'h0;
		endcase
	end

	// Levels are read before the input enables, so a key works on a gated pin
	// A pin outside the group never holds the reset off
	for (genvar k = 0; k < 4; k++)
	begin : g_key
		assign keyPressed[k] = ~keyMask[k] | ~state_q.sync0Stage2[k];
	end

	// An empty group must never fire, so the off code is tested on its own
	assign keyAllLow = (keyMask != 4'h0) && (&keyPressed);

	//////////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	always_comb
	begin
		case (wb_adr_i)
			KEY_RESET_CONFIG_ADDR:         rdByte = {6'h00, state_q.keyResetGroupSel};
			PORT0_INPUT_ENABLE_ADDR:       rdByte = state_q.port0InputEnable;
			PORT1_INPUT_ENABLE_ADDR:       rdByte = {4'h0, state_q.port1InputEnable};
			LOW_PINS_FUNCTION_SELECT_ADDR: rdByte = funcSelReg;
			PORT0_INPUT_DATA_ADDR:         rdByte = state_q.port0InputData;
			PORT1_INPUT_DATA_ADDR:         rdByte = {4'h0, state_q.port1InputData};
			default:                       rdByte = 8'h00;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		state_d = state_q;

		// Pad synchronisers
		state_d.sync0Stage1 = port0PinIn;
		state_d.sync0Stage2 = state_q.sync0Stage1;
		state_d.sync1Stage1 = port1PinIn;
		state_d.sync1Stage2 = state_q.sync1Stage1;

		// Input data follows the gated pad level every cycle
		state_d.port0InputData = gatedPort0;
		state_d.port1InputData = gatedPort1;

		// Bus answer
		state_d.ack      = busReq;
		state_d.readData = busReq ? {24'h000000, rdByte} : state_q.readData;

		if (busWrite)
		begin
			case (wb_adr_i)
				KEY_RESET_CONFIG_ADDR:
				begin
					state_d.keyResetGroupSel = wrByte[1:0];
				end
				PORT0_INPUT_ENABLE_ADDR:
				begin
					state_d.port0InputEnable = wrByte;
				end
				PORT1_INPUT_ENABLE_ADDR:
				begin
					state_d.port1InputEnable = wrByte[PORT1_PINS-1:0];
				end
				LOW_PINS_FUNCTION_SELECT_ADDR:
				begin
					state_d.pin0FunctionSel = wrByte[PIN0_SEL_LSB +: 2];
					state_d.pin1FunctionSel = wrByte[PIN1_SEL_LSB +: 2];
					state_d.pin2FunctionSel = wrByte[PIN2_SEL_LSB +: 2];
					state_d.pin3FunctionSel = wrByte[PIN3_SEL_LSB +: 2];
				end
				PORT0_INPUT_DATA_ADDR, PORT1_INPUT_DATA_ADDR:
				begin
					// Input data follows the pins; a write is answered and dropped
				end
				default:
				begin
					state_d.keyResetGroupSel = state_q.keyResetGroupSel;
				end
			endcase
		end

		// Held while the selected keys stay low; the chip reset then clears the select
		state_d.keyReset = keyAllLow;

		// Upper pins stay on GPIO here
		state_d.pinOut = gpio0Out;
		state_d.pinOe  = gpio0Oe;

		// Pin 0
		case (state_q.pin0FunctionSel)
			PIN0_FUNC_UARTRX:
			begin
				state_d.pinOut[0] = 1'b0;
				state_d.pinOe[0]  = 1'b0;
			end
			default:
			begin
				state_d.pinOut[0] = gpio0Out[0];
				state_d.pinOe[0]  = gpio0Oe[0];
			end
		endcase

		// Pin 1
		case (state_q.pin1FunctionSel)
			PIN1_FUNC_UARTTX:
			begin
				state_d.pinOut[1] = uartTxOut;
				state_d.pinOe[1]  = 1'b1;
			end
			default:
			begin
				state_d.pinOut[1] = gpio0Out[1];
				state_d.pinOe[1]  = gpio0Oe[1];
			end
		endcase

		// Pin 2
		case (state_q.pin2FunctionSel)
			PIN2_FUNC_SCLK:
			begin
				state_d.pinOut[2] = uartSerialClockOut;
				state_d.pinOe[2]  = uartSerialClockOe;
			end
			PIN2_FUNC_CLKA:
			begin
				state_d.pinOut[2] = clockGenOutputA;
				state_d.pinOe[2]  = 1'b1;
			end
			default:
			begin
				state_d.pinOut[2] = gpio0Out[2];
				state_d.pinOe[2]  = gpio0Oe[2];
			end
		endcase

		// Pin 3
		case (state_q.pin3FunctionSel)
			PIN3_FUNC_TIMCLK:
			begin
				state_d.pinOut[3] = 1'b0;
				state_d.pinOe[3]  = 1'b0;
			end
			PIN3_FUNC_LCDFR:
			begin
				state_d.pinOut[3] = lcdFrameSignal;
				state_d.pinOe[3]  = 1'b1;
			end
			default:
			begin
				state_d.pinOut[3] = gpio0Out[3];
				state_d.pinOe[3]  = gpio0Oe[3];
			end
		endcase

		// Routed peripheral inputs see the gated pin; others rest at idle level
		state_d.uartRx     = 1'b1;
		state_d.uartSclkIn = 1'b0;
		state_d.timerClkIn = 1'b0;
		if (state_q.pin0FunctionSel == PIN0_FUNC_UARTRX)
		begin
			state_d.uartRx = gatedPort0[0];
		end
		if (state_q.pin2FunctionSel == PIN2_FUNC_SCLK)
		begin
			state_d.uartSclkIn = gatedPort0[2];
		end
		if (state_q.pin3FunctionSel == PIN3_FUNC_TIMCLK)
		begin
			state_d.timerClkIn = gatedPort0[3];
		end

		// Reset stands last so that it overrides every update above
		if (sys_rst)
		begin
			state_d                  = '0;
			state_d.keyResetGroupSel = KEY_RESET_GROUP_SEL_RST;
			state_d.port0InputEnable = PORT0_INPUT_ENABLE_RST;
			state_d.port1InputEnable = PORT1_INPUT_ENABLE_RST;
			state_d.pin0FunctionSel  = FUNCTION_SELECT_RST[PIN0_SEL_LSB +: 2];
			state_d.pin1FunctionSel  = FUNCTION_SELECT_RST[PIN1_SEL_LSB +: 2];
			state_d.pin2FunctionSel  = FUNCTION_SELECT_RST[PIN2_SEL_LSB +: 2];
			state_d.pin3FunctionSel  = FUNCTION_SELECT_RST[PIN3_SEL_LSB +: 2];
			state_d.uartRx           = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk)
	begin
		state_q <= state_d;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Every output comes straight from a flip-flop of the state record
	assign wb_ack_o          = state_q.ack;
	assign wb_dat_o          = state_q.readData;
	assign port0PinOut       = state_q.pinOut;
	assign port0PinOe        = state_q.pinOe;
	assign uartRxIn          = state_q.uartRx;
	assign uartSerialClockIn = state_q.uartSclkIn;
	assign timerExtClockIn   = state_q.timerClkIn;
	assign keyResetReq       = state_q.keyReset;

endmodule : pkrps_top
